// ### src/ues_cfg.svh
// Purpose: Offsets, field positions and reset values of the event/shortcut registers.
// Assumes: Byte addresses, word aligned, decoded on the low 12 address bits.
// Notes: Definitions only.
`ifndef UES_CFG_SVH
`define UES_CFG_SVH
`define UES_ADDR_W 12
`define UES_OFS_FLOW_ON 12'h100
`define UES_OFS_FLOW_OFF 12'h104
`define UES_OFS_RX_READY 12'h108
`define UES_OFS_TX_DONE 12'h11c
`define UES_OFS_ERROR 12'h124
`define UES_OFS_RX_TIMEOUT 12'h144
`define UES_OFS_EVENT_TASK_SHORTCUTS 12'h200
`define UES_OFS_IRQ_STATUS 12'h400
`define UES_OFS_IRQ_MASK 12'h404
`define UES_NUM_EV 6
`define UES_EV_FLOW_ON 0
`define UES_EV_FLOW_OFF 1
`define UES_EV_RX_READY 2
`define UES_EV_TX_DONE 3
`define UES_EV_ERROR 4
`define UES_EV_RX_TIMEOUT 5
`define UES_SHORT_START_BIT 0
`define UES_SHORT_STOP_BIT 1
`define UES_RST_FLAG 1'h0
`define UES_RST_EVENT_TASK_SHORTCUTS 2'h0
`define UES_RST_EV6 6'h00
`define UES_RST_WORD 32'h0000_0000
`define UES_CTS_IDLE 1'h1
`define UES_HTRANS_NONSEQ_BIT 1
`endif

// ### src/ues_pkg.sv
// Purpose: Types shared by the event/shortcut register block.
// Assumes: Constants live in ues_cfg.svh.
// Notes: Bus slave state only.
package ues_pkg;
  // Bus slave phase
  typedef enum logic [0:0] {
    UES_BUS_IDLE,
    UES_BUS_RD
  } ues_bus_state_t;
endpackage : ues_pkg

// ### src/ues_reg_if.sv
// Purpose: Carrier between the AHB-Lite slave and the register file.
// Assumes: One strobe per access, all on hclk.
// Notes: rdata is combinational from the register file.
`timescale 1ns/100ps
interface ues_reg_if;
  logic wr_en;
  logic rd_en;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  // Bus end drives strobes
  modport bus (output wr_en, output rd_en, output addr, output wdata, input rdata);
  // Register end answers
  modport regs (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : ues_reg_if

// ### src/ues_cts_sync.sv
// Purpose: Synchronise the clear-to-send pin and detect its edges.
// Assumes: Pin is asynchronous to hclk, active low.
// Notes: Pulses are one hclk cycle, one to two cycles after the pin moves.
`timescale 1ns/100ps
`include "ues_cfg.svh"
module ues_cts_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pin
  input wire logic cts_n,
  // Edge pulses
  output logic flow_on_pulse,
  output logic flow_off_pulse
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;

  // Two-stage synchroniser plus history; idle level avoids a false edge at reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= `UES_CTS_IDLE;
      sync2_ff <= `UES_CTS_IDLE;
      prev_ff <= `UES_CTS_IDLE;
    end else begin
      sync1_ff <= cts_n;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Falling edge is activation, rising edge is deactivation
  assign flow_on_pulse = prev_ff & ~sync2_ff;
  assign flow_off_pulse = ~prev_ff & sync2_ff;
endmodule : ues_cts_sync

// ### src/ues_ahb_slave.sv
// Purpose: AHB-Lite slave front end of the event/shortcut registers.
// Assumes: Single word transfers; response always OKAY.
// Notes: Writes take no wait state, reads take one so read data comes from a flop.
`timescale 1ns/100ps
`include "ues_cfg.svh"
module ues_ahb_slave
  import ues_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave pins
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register side
  ues_reg_if.bus regs
);
  ues_bus_state_t state_ff;
  logic wr_pend_ff;
  logic [11:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic accept;

  assign accept = hsel & htrans[`UES_HTRANS_NONSEQ_BIT] & hready;

  // Address phase capture and read wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= UES_BUS_IDLE;
      wr_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
      hreadyout_ff <= 1'b1;
    end else if (accept) begin
      addr_ff <= haddr[11:0];
      wr_pend_ff <= hwrite;
      state_ff <= hwrite ? UES_BUS_IDLE : UES_BUS_RD;
      hreadyout_ff <= hwrite;
    end else begin
      wr_pend_ff <= 1'b0;
      state_ff <= UES_BUS_IDLE;
      hreadyout_ff <= 1'b1;
    end
  end

  // Read data sampled after any write in flight has landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= `UES_RST_WORD;
    end else if (state_ff == UES_BUS_RD) begin
      hrdata_ff <= regs.rdata;
    end
  end

  assign regs.wr_en = wr_pend_ff;
  assign regs.rd_en = (state_ff == UES_BUS_RD);
  assign regs.addr = addr_ff;
  assign regs.wdata = hwdata;
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = 1'b0;
endmodule : ues_ahb_slave

// ### src/ues_top.sv
// Purpose: Event flags, interrupt status and event-to-task shortcuts of a UART.
// Assumes: Datapath indications are one-cycle pulses on hclk; cts_n is a raw pin.
// Notes: Registers sit on AHB-Lite; all outputs are registered.
// Function
// - The flow-on flag goes to 1 when the clear-to-send pin goes low, and reads 0 before unless software writes 1.
// - The flow-off flag goes to 1 when the clear-to-send pin goes high.
// - The receive-ready flag goes to 1 when a received byte lands in the holding register.
// - The transmit-done flag goes to 1 when the held byte has left on the line.
// - The error flag goes to 1 on each detected reception error and otherwise changes only by a software write.
// - With shortcut bit 0 set, each flow-on event starts the receiver, otherwise never.
// - With shortcut bit 1 set, each flow-off event stops the receiver, otherwise never.
`timescale 1ns/100ps
`include "ues_cfg.svh"
module ues_top
  import ues_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flow control pin from the remote peer
  input wire logic cts_n,
  // Indications from the serial datapath
  input wire logic rx_byte_stored,
  input wire logic tx_byte_sent,
  input wire logic rx_error_seen,
  input wire logic rx_timeout_seen,
  // Tasks to the serial datapath
  output logic receiver_start_task,
  output logic receiver_stop_task,
  // Interrupt
  output logic irq
);
  ues_reg_if bus_if ();

  logic flow_on_pulse;
  logic flow_off_pulse;
  logic [`UES_NUM_EV-1:0] ev;
  logic [`UES_NUM_EV-1:0] event_flag_ff;
  logic [`UES_NUM_EV-1:0] irq_status_ff;
  logic [`UES_NUM_EV-1:0] irq_mask_ff;
  logic [1:0] event_task_shortcuts_ff;
  logic receiver_start_task_ff;
  logic receiver_stop_task_ff;
  logic irq_ff;
  logic status_read;
  logic mask_write;
  logic event_task_shortcuts_write;
  logic [31:0] nxt_rdata;

  // Word size is the only one used, so hsize is not decoded
  logic hsize_unused;
  assign hsize_unused = ^hsize;

  // Byte offset of each event flag, indexed as the event vector
  localparam logic [11:0] EV_OFS [`UES_NUM_EV] = '{
    `UES_OFS_FLOW_ON,
    `UES_OFS_FLOW_OFF,
    `UES_OFS_RX_READY,
    `UES_OFS_TX_DONE,
    `UES_OFS_ERROR,
    `UES_OFS_RX_TIMEOUT
  };

  // Bus front end
  ues_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .regs(bus_if.bus)
  );

  // Pin synchroniser and edge detector
  ues_cts_sync u_cts (
    .hclk(hclk),
    .hresetn(hresetn),
    .cts_n(cts_n),
    .flow_on_pulse(flow_on_pulse),
    .flow_off_pulse(flow_off_pulse)
  );

  // Event sources; datapath pulses share hclk so they need no synchroniser
  always_comb begin
    ev = `UES_RST_EV6;
    ev[`UES_EV_FLOW_ON] = flow_on_pulse;
    ev[`UES_EV_FLOW_OFF] = flow_off_pulse;
    ev[`UES_EV_RX_READY] = rx_byte_stored;
    ev[`UES_EV_TX_DONE] = tx_byte_sent;
    ev[`UES_EV_ERROR] = rx_error_seen;
    ev[`UES_EV_RX_TIMEOUT] = rx_timeout_seen;
  end

  // Register strobes decoded from the bus carrier
  assign status_read = bus_if.rd_en & (bus_if.addr == `UES_OFS_IRQ_STATUS);
  assign mask_write = bus_if.wr_en & (bus_if.addr == `UES_OFS_IRQ_MASK);
  assign event_task_shortcuts_write = bus_if.wr_en & (bus_if.addr == `UES_OFS_EVENT_TASK_SHORTCUTS);

  // Per-event flag and sticky status; an event in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < `UES_NUM_EV; gi++) begin : g_ev
      // Flag: set by hardware, written by software in bit 0
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          event_flag_ff[gi] <= `UES_RST_FLAG;
        end else if (ev[gi]) begin
          event_flag_ff[gi] <= 1'b1;
        end else if (bus_if.wr_en && (bus_if.addr == EV_OFS[gi])) begin
          event_flag_ff[gi] <= bus_if.wdata[0];
        end
      end

      // Interrupt status: cleared by reading it, independent of the flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_status_ff[gi] <= `UES_RST_FLAG;
        end else if (ev[gi]) begin
          irq_status_ff[gi] <= 1'b1;
        end else if (status_read) begin
          irq_status_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt mask, same layout as the status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_ff <= `UES_RST_EV6;
    end else if (mask_write) begin
      irq_mask_ff <= bus_if.wdata[`UES_NUM_EV-1:0];
    end
  end

  // Shortcut enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_task_shortcuts_ff <= `UES_RST_EVENT_TASK_SHORTCUTS;
    end else if (event_task_shortcuts_write) begin
      event_task_shortcuts_ff <= bus_if.wdata[1:0];
    end
  end

  // Tasks fired from events; registered so the datapath sees a clean one-cycle pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      receiver_start_task_ff <= 1'b0;
      receiver_stop_task_ff <= 1'b0;
    end else begin
      receiver_start_task_ff <= flow_on_pulse &
        event_task_shortcuts_ff[`UES_SHORT_START_BIT];
      receiver_stop_task_ff <= flow_off_pulse &
        event_task_shortcuts_ff[`UES_SHORT_STOP_BIT];
    end
  end

  // Level interrupt; one cycle behind the status, the price of a flopped output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero
  always_comb begin
    nxt_rdata = `UES_RST_WORD;
    unique case (bus_if.addr)
      `UES_OFS_FLOW_ON: nxt_rdata[0] = event_flag_ff[`UES_EV_FLOW_ON];
      `UES_OFS_FLOW_OFF: nxt_rdata[0] = event_flag_ff[`UES_EV_FLOW_OFF];
      `UES_OFS_RX_READY: nxt_rdata[0] = event_flag_ff[`UES_EV_RX_READY];
      `UES_OFS_TX_DONE: nxt_rdata[0] = event_flag_ff[`UES_EV_TX_DONE];
      `UES_OFS_ERROR: nxt_rdata[0] = event_flag_ff[`UES_EV_ERROR];
      `UES_OFS_RX_TIMEOUT: nxt_rdata[0] = event_flag_ff[`UES_EV_RX_TIMEOUT];
      `UES_OFS_EVENT_TASK_SHORTCUTS: nxt_rdata[1:0] = event_task_shortcuts_ff;
      `UES_OFS_IRQ_STATUS: nxt_rdata[`UES_NUM_EV-1:0] = irq_status_ff;
      `UES_OFS_IRQ_MASK: nxt_rdata[`UES_NUM_EV-1:0] = irq_mask_ff;
      default: nxt_rdata = `UES_RST_WORD;
    endcase
  end
  assign bus_if.rdata = nxt_rdata;

  // Outputs straight from flops
  assign receiver_start_task = receiver_start_task_ff;
  assign receiver_stop_task = receiver_stop_task_ff;
  assign irq = irq_ff;

  // Flow-on edge raises its flag one cycle later
  a_flow_on_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    flow_on_pulse |=> event_flag_ff[`UES_EV_FLOW_ON])
    else $error("flow-on flag not set after pin fell");

  // Flow-on flag never rises without its edge or a write
  a_flow_on_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(event_flag_ff[`UES_EV_FLOW_ON]) |->
      ($past(flow_on_pulse) || $past(bus_if.wr_en)))
    else $error("flow-on flag rose without cause");

  // Flow-off edge raises its flag
  a_flow_off_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    flow_off_pulse |=> event_flag_ff[`UES_EV_FLOW_OFF])
    else $error("flow-off flag not set after pin rose");

  // Stored byte raises the receive-ready flag and status
  a_rx_ready_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_byte_stored |=> (event_flag_ff[`UES_EV_RX_READY] && irq_status_ff[`UES_EV_RX_READY]))
    else $error("receive-ready flag or status missing");

  // Sent byte raises the transmit-done flag
  a_tx_done_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    tx_byte_sent |=> event_flag_ff[`UES_EV_TX_DONE])
    else $error("transmit-done flag not set");

  // Error flag rises only on an error or a software write
  a_error_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(event_flag_ff[`UES_EV_ERROR]) |->
      ($past(rx_error_seen) || $past(bus_if.wr_en && bus_if.wdata[0])))
    else $error("error flag rose without an error");

  // Start shortcut follows the enable bit both ways
  a_start_short: assert property (
    @(posedge hclk) disable iff (!hresetn)
    flow_on_pulse |=>
      (receiver_start_task == $past(event_task_shortcuts_ff[`UES_SHORT_START_BIT])))
    else $error("receiver start does not follow its shortcut");

  // No stray stop: no stop task without a flow-off edge
  a_stop_short: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !flow_off_pulse |=> !receiver_stop_task)
    else $error("receiver stop without flow-off event");

  // Stop fires on an enabled flow-off edge
  a_stop_fires: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flow_off_pulse && event_task_shortcuts_ff[`UES_SHORT_STOP_BIT]) |=> receiver_stop_task)
    else $error("enabled stop shortcut did not fire");

  // Writing 0 to a quiet flag clears it and it stays clear while quiet
  a_flag_write_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (bus_if.wr_en && bus_if.addr == `UES_OFS_TX_DONE && !bus_if.wdata[0] && !tx_byte_sent)
      ##1 (!tx_byte_sent && !(bus_if.wr_en && bus_if.addr == `UES_OFS_TX_DONE))
      |=> !event_flag_ff[`UES_EV_TX_DONE])
    else $error("transmit-done flag survived a write of zero");

  // Interrupt level tracks masked status one cycle behind
  a_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq == $past(|(irq_status_ff & irq_mask_ff)))
    else $error("interrupt level does not match masked status");

  // Flow-off flag never rises without its edge or a write
  a_flow_off_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(event_flag_ff[`UES_EV_FLOW_OFF]) |-> ($past(flow_off_pulse) || $past(bus_if.wr_en)))
    else $error("flow-off flag rose without cause");

  // Receive-ready flag rises only on a stored byte or a write
  a_rx_ready_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(event_flag_ff[`UES_EV_RX_READY]) |-> ($past(rx_byte_stored) || $past(bus_if.wr_en)))
    else $error("receive-ready flag rose without cause");

  // Transmit-done flag rises only on a sent byte or a write
  a_tx_done_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(event_flag_ff[`UES_EV_TX_DONE]) |-> ($past(tx_byte_sent) || $past(bus_if.wr_en)))
    else $error("transmit-done flag rose without cause");

  // Each detected error raises the error flag
  a_error_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_error_seen |=> event_flag_ff[`UES_EV_ERROR])
    else $error("error flag not set after an error");

  // No receiver start without a flow-on edge
  a_start_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !flow_on_pulse |=> !receiver_start_task)
    else $error("receiver start without flow-on event");

  // Disabled stop shortcut never stops the receiver
  a_stop_disabled: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flow_off_pulse && !event_task_shortcuts_ff[`UES_SHORT_STOP_BIT]) |=> !receiver_stop_task)
    else $error("disabled stop shortcut fired");

  // Writing 1 to a flag sets it
  a_flag_write_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (bus_if.wr_en && bus_if.addr == `UES_OFS_RX_READY && bus_if.wdata[0])
      |=> event_flag_ff[`UES_EV_RX_READY])
    else $error("receive-ready flag not set by a write of one");

  // A set flag stays set until software writes its word
  a_flag_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (event_flag_ff[`UES_EV_FLOW_ON] && !(bus_if.wr_en && bus_if.addr == `UES_OFS_FLOW_ON))
      |=> event_flag_ff[`UES_EV_FLOW_ON])
    else $error("flow-on flag dropped without a write");

  // Reading the status with no event pending clears every bit
  a_status_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (status_read && (ev == `UES_RST_EV6)) |=> (irq_status_ff == `UES_RST_EV6))
    else $error("interrupt status not cleared by its read");

  // Receiver timeout raises its flag
  a_rx_timeout_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_timeout_seen |=> event_flag_ff[`UES_EV_RX_TIMEOUT])
    else $error("receiver timeout flag not set");

  // A read wait state lasts exactly one cycle
  a_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hreadyout |=> hreadyout)
    else $error("read wait state longer than one cycle");

  // The pin edge detector never reports both edges at once
  a_cts_edges: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(flow_on_pulse && flow_off_pulse))
    else $error("both pin edges reported in one cycle");
endmodule : ues_top

// ### verification/ues_peer_model.sv
// Purpose: Remote serial peer that drives the clear-to-send pin.
// Assumes: The bench says when the peer is ready to receive.
// Notes: The pin moves 7 ns after an hclk edge, so it is never aligned to the sampling edge.
`timescale 1ns/100ps
module ues_peer_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Command from the bench
  input wire logic want_clear,
  // Pin to the device
  output logic cts_n
);
  // Idle high during reset so no flow-on event appears at release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_n <= 1'h1;
    end else if (want_clear == cts_n) begin
      cts_n <= #7 !want_clear; // Active low: ready means low
    end
  end
endmodule : ues_peer_model

// ### verification/uart_event_shortcut_regs_bench.sv
// Purpose: Self-checking bench of the event flag and shortcut registers.
// Assumes: One AHB-Lite slave, so hready is hreadyout.
// Notes: Reads queue their expected word; a monitor compares when the data phase ends.
`timescale 1ns/100ps
`include "ues_cfg.svh"
module uart_event_shortcut_regs_bench;
  logic hclk, hresetn, hsel, hwrite, want_clear;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [3:0] dp_ev;
  logic hready, hresp, cts_n, start_task, stop_task, irq, rd_pend;
  logic [31:0] exp_q[$];
  logic [31:0] seed, r;
  logic [7:0] n_start, n_stop, st0, sp0;
  logic [31:0] reset_map[9];
  logic [31:0] ev_ofs[4];
  logic [1:0] event_task_shortcuts_tab[4];
  int num_errors, total_checks;
  wire logic hreadyout_w;
  assign hready = hreadyout_w;
  ues_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hsize(3'h2), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout_w), .hresp(hresp), .cts_n(cts_n), .rx_byte_stored(dp_ev[0]),
    .tx_byte_sent(dp_ev[1]), .rx_error_seen(dp_ev[2]), .rx_timeout_seen(dp_ev[3]),
    .receiver_start_task(start_task), .receiver_stop_task(stop_task), .irq(irq));
  ues_peer_model peer (.hclk(hclk), .hresetn(hresetn), .want_clear(want_clear), .cts_n(cts_n));
  // Free-running 40 MHz clock
  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic cmp_rdata(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_rdata
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'h1) begin
      n++;
      if (n > 40) begin
        num_errors++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask : wait_ready
  task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask : ahb_xfer
  task automatic ahb_read(input logic [31:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    ahb_xfer(a, 1'h0, 32'h0);
  endtask : ahb_read
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_cyc
  task automatic pulse_ev(input int i);
    @(posedge hclk);
    dp_ev <= 4'h1 << i;
    @(posedge hclk);
    dp_ev <= 4'h0;
  endtask : pulse_ev
  // Read monitor: the data phase ends at the edge where hready is seen high
  always @(posedge hclk) begin
    if (rd_pend && hready === 1'h1) begin
      if (exp_q.size() == 0) begin
        cmp_rdata(hrdata, 32'hffff_ffff);
      end else begin
        cmp_rdata(hrdata, exp_q.pop_front());
      end
      cmp_val({7'h0, hresp}, 8'h0);
      rd_pend = 1'h0;
    end
    if (hsel && htrans[1] && hready && !hwrite) begin
      rd_pend = 1'h1;
    end
  end
  // Count one-cycle task pulses towards the receiver
  always @(posedge hclk) begin
    if (start_task === 1'h1) n_start++;
    if (stop_task === 1'h1) n_stop++;
  end
  // Hang guard
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    hresetn = 1'h0; hsel = 1'h0; hwrite = 1'h0; haddr = 32'h0; hwdata = 32'h0;
    htrans = 2'h0; dp_ev = 4'h0; want_clear = 1'h0; rd_pend = 1'h0;
    n_start = 8'h0; n_stop = 8'h0; seed = 32'd83582;
    reset_map = '{`UES_OFS_FLOW_ON, `UES_OFS_FLOW_OFF, `UES_OFS_RX_READY, `UES_OFS_TX_DONE,
      `UES_OFS_ERROR, `UES_OFS_RX_TIMEOUT, `UES_OFS_EVENT_TASK_SHORTCUTS, `UES_OFS_IRQ_STATUS,
      `UES_OFS_IRQ_MASK};
    ev_ofs = '{`UES_OFS_RX_READY, `UES_OFS_TX_DONE, `UES_OFS_ERROR, `UES_OFS_RX_TIMEOUT};
    event_task_shortcuts_tab = '{2'h0, 2'h3, 2'h1, 2'h2};
    wait_cyc(5);
    hresetn <= 1'h1;
    // Every register starts at zero
    foreach (reset_map[k]) ahb_read(reset_map[k], 32'h0);
    // Masked interrupt: only the transmit-done bit may raise irq
    ahb_write_mask: ahb_xfer(`UES_OFS_IRQ_MASK, 1'h1, 32'h0000_0008);
    ahb_read(`UES_OFS_IRQ_MASK, 32'h0000_0008);
    pulse_ev(0);
    wait_cyc(4);
    cmp_val({7'h0, irq}, 8'h0);
    pulse_ev(1);
    wait_cyc(4);
    cmp_val({7'h0, irq}, 8'h1);
    ahb_read(`UES_OFS_IRQ_STATUS, 32'h0000_000c);
    wait_cyc(2);
    cmp_val({7'h0, irq}, 8'h0);
    ahb_xfer(`UES_OFS_IRQ_STATUS, 1'h1, 32'hffff_ffff);
    ahb_read(`UES_OFS_IRQ_STATUS, 32'h0);
    // Unmapped place ignores writes and reads zero
    ahb_xfer(32'h0000_0300, 1'h1, xs());
    ahb_read(32'h0000_0300, 32'h0);
    // Datapath flags: clear, set by the event, then bit 0 stores written data
    for (int i = 0; i < 4; i++) begin
      ahb_xfer(ev_ofs[i], 1'h1, 32'h0);
      ahb_read(ev_ofs[i], 32'h0);
      pulse_ev(i);
      ahb_read(ev_ofs[i], 32'h1);
      r = xs();
      ahb_xfer(ev_ofs[i], 1'h1, r);
      ahb_read(ev_ofs[i], {31'h0, r[0]});
    end
    // Flow-control events under each shortcut setting
    foreach (event_task_shortcuts_tab[k]) begin
      r = xs();
      ahb_xfer(`UES_OFS_EVENT_TASK_SHORTCUTS, 1'h1, {r[31:2], event_task_shortcuts_tab[k]});
      ahb_read(`UES_OFS_EVENT_TASK_SHORTCUTS, {30'h0, event_task_shortcuts_tab[k]});
      ahb_xfer(`UES_OFS_FLOW_ON, 1'h1, 32'h0);
      ahb_xfer(`UES_OFS_FLOW_OFF, 1'h1, 32'h0);
      st0 = n_start;
      sp0 = n_stop;
      want_clear <= 1'h1;
      wait_cyc(10);
      ahb_read(`UES_OFS_FLOW_ON, 32'h1);
      ahb_read(`UES_OFS_FLOW_OFF, 32'h0);
      cmp_val(n_start - st0, {7'h0, event_task_shortcuts_tab[k][0]});
      cmp_val(n_stop - sp0, 8'h0);
      want_clear <= 1'h0;
      wait_cyc(10);
      ahb_read(`UES_OFS_FLOW_OFF, 32'h1);
      cmp_val(n_stop - sp0, {7'h0, event_task_shortcuts_tab[k][1]});
      cmp_val(n_start - st0, {7'h0, event_task_shortcuts_tab[k][0]});
    end
    wait_cyc(4);
    cmp_val(8'(exp_q.size()), 8'h0);
    complete_run();
  end
endmodule : uart_event_shortcut_regs_bench
